// File: spw_pkg.sv
// spw_pkg: register map, field positions, reset values and timing figures
// of the single-output pwm channel with its three 8-bit period timers.
// assumes a 32-bit apb slave with byte addresses, one register per word.
package spw_pkg;
  // byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;  // module_control
  localparam logic [7:0] ADR_DUTYH  = 8'h04;  // duty_high_bits
  localparam logic [7:0] ADR_SHADOW = 8'h08;  // duty_shadow
  localparam logic [7:0] ADR_TSEL   = 8'h0c;  // timer_select_reg
  localparam logic [7:0] ADR_DIR    = 8'h10;  // pin_direction
  localparam logic [7:0] ADR_FLAG   = 8'h14;  // period_flag per timer, w1c
  localparam logic [7:0] ADR_TCTL   = 8'h18;  // timer_control 0..2
  localparam logic [7:0] ADR_PLIM   = 8'h24;  // period_limit 0..2
  localparam logic [7:0] ADR_PCNT   = 8'h30;  // period_counter 0..2
  localparam int         NUM_TMR    = 3;
  // module_control fields
  localparam int         CTRL_DLO_LSB  = 4;   // duty_low_bits at 5:4
  localparam logic [1:0] CTRL_MODE_PWM = 2'h3; // mode bits 3:2 = 11
  // timer_control fields
  localparam int         TCTL_RUN_BIT  = 2;   // timer_run
  localparam int         TCTL_POST_LSB = 3;   // postscale 6:3
  // reset values
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_DUTY  = 8'h00;
  localparam logic [1:0] RST_TSEL  = 2'h0;
  localparam logic       RST_DIR   = 1'b1;    // pin is an input
  localparam logic [6:0] RST_TCTL  = 7'h00;
  localparam logic [7:0] RST_PLIM  = 8'hff;
  // prescale select codes and divider terminal counts
  typedef enum logic [1:0] {
    SPW_PRE1  = 2'b00,
    SPW_PRE4  = 2'b01,
    SPW_PRE16 = 2'b10
  } spw_pre_t;
  localparam logic [3:0] PRE_END1  = 4'h0;
  localparam logic [3:0] PRE_END4  = 4'h3;
  localparam logic [3:0] PRE_END16 = 4'hf;
  localparam int         TOSC_PER_INC = 4;    // clock periods per timer step at 1:1
endpackage : spw_pkg

// File: spw_timer.sv
// spw_timer: one 8-bit period timer with prescaler and 2-bit time-base
// extension. assumes run, freeze and limit come from logic on pclk.
`timescale 1ns/1ps
module spw_timer (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              run,
  input  wire logic              frz,
  input  wire spw_pkg::spw_pre_t pre_sel,
  input  wire logic [7:0]        limit,
  output logic      [7:0]        cnt,
  output logic      [1:0]        low,
  output logic                   wrap
);
  import spw_pkg::*;

  logic [3:0] div_ff;
  logic [1:0] sub_ff;
  logic [7:0] cnt_ff;
  logic       adv;
  logic       div_end;
  logic       step;
  logic [1:0] nxt_sub;
  logic [7:0] nxt_cnt;

  // terminal count of the prescaler divider
  function automatic logic [3:0] pre_end(input spw_pre_t s);
    case (s)
      SPW_PRE1:  pre_end = PRE_END1;
      SPW_PRE4:  pre_end = PRE_END4;
      SPW_PRE16: pre_end = PRE_END16;
      default:   pre_end = PRE_END16;
    endcase
  endfunction : pre_end

  // sleep freezes everything, so counting resumes where it stopped
  assign adv     = run & ~frz;
  assign div_end = (div_ff == pre_end(pre_sel));
  assign step    = adv & div_end & (sub_ff == 2'h3);
  assign wrap    = step & (cnt_ff == limit);
  // the channel sees the base that this edge is about to show, so its
  // registered set and clear land on the same edges as the base itself
  assign nxt_sub = (adv && div_end) ? sub_ff + 2'h1 : sub_ff;
  assign nxt_cnt = step ? (wrap ? 8'h00 : cnt_ff + 8'h01) : cnt_ff;
  assign cnt     = nxt_cnt;
  assign low     = nxt_sub;

  // prescaler divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 4'h0;
    end else if (adv) begin
      div_ff <= div_end ? 4'h0 : div_ff + 4'h1;
    end
  end

  // two low time-base bits: a count of prescaler rollovers, the clock phase at 1:1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_ff <= 2'h0;
    end else if (adv && div_end) begin
      sub_ff <= sub_ff + 2'h1;
    end
  end

  // period counter clears on the step after it equals the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 8'h00;
    end else if (step) begin
      cnt_ff <= wrap ? 8'h00 : cnt_ff + 8'h01;
    end
  end

  a_wrap_clears : assert property (@(posedge pclk) disable iff (!presetn)
    wrap |=> cnt_ff == 8'h00) else $error("counter not cleared after wrap");
  a_freeze_hold : assert property (@(posedge pclk) disable iff (!presetn)
    frz |=> $stable(cnt_ff) && $stable(sub_ff)) else $error("timer moved in sleep");
  a_step_gap : assert property (@(posedge pclk) disable iff (!presetn)
    step |=> !step [*3]) else $error("timer stepped faster than four clocks");
endmodule : spw_timer

// File: spw_pwm.sv
// spw_pwm: standard pwm channel with apb registers, timer selection and
// double-buffered 10-bit duty. assumes a zero-wait-capable apb master on
// pclk and a sleep request that is synchronous to pclk.
// the output is a register: it rises on the wrap edge and falls on the edge at
// which the time base reaches the buffered duty, so high time is exact.
// duty writes wait in duty_high_bits and module_control until the next wrap;
// limitation: a stopped or unselected timer freezes the output level, and a
// duty beyond the period keeps it high for the whole period.
//
// Notes on behaviour
// - after counter equals limit, next step clears it, sets output, loads shadow.
// - a zero duty value never sets the output at period start.
// - period is (limit+1) times four clocks times prescale factor.
// - postscale bits are stored but never affect pwm timing.
// - duty is duty_high_bits above the two duty_low_bits of module_control.
// - duty registers take writes any time; value applies next period.
// - in pwm mode duty_shadow reads back and ignores writes.
// - duty buffered in shadow plus hidden two-bit latch, no glitches.
// - time base is counter plus two bits counting prescaler rollovers.
// - output clears when time base equals buffered duty.
// - high time equals duty times clock period times prescale.
// - resolution is log2 of four times (limit+1) bits.
// - duty beyond the period never matches, output holds.
// - sleep freezes counter and channel, output level held.
// - a two-bit field routes one of three timers to the channel.
// - period flag sets on each rollover of a timer.
// - writing zero to module_control releases the pin.
// - pwm reaches the pin only while pin_direction is output.
// - reset restores all registers and makes the pin an input.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module spw_pwm (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_req,
  output logic             pwm_output,
  output logic             pwm_output_oe
);
  import spw_pkg::*;

  logic [7:0]  ctrl_ff;
  logic [7:0]  duty_high_ff;
  logic [7:0]  shadow_ff;
  logic [1:0]  latch_ff;
  logic [1:0]  tsel_ff;
  logic        dir_ff;
  logic [2:0]  flag_ff;
  logic [6:0]  tctl_ff [0:NUM_TMR-1];
  logic [7:0]  plim_ff [0:NUM_TMR-1];
  logic        out_ff;
  logic        oe_ff;
  logic [31:0] prdata_ff;
  logic        slverr_ff;
  logic [7:0]  cnt_w   [0:NUM_TMR-1];
  logic [1:0]  low_w   [0:NUM_TMR-1];
  logic [2:0]  wrap_w;
  logic        wr;
  logic        setup;
  logic        pwm_mode;
  logic        s_wrap;
  logic [9:0]  s_base;
  logic [9:0]  duty_new;
  logic [9:0]  duty_buf;
  logic [31:0] rd_val;
  logic        rd_ok;

  // one-hot hit on a group of three consecutive timer registers
  function automatic logic [2:0] hit3(input logic [7:0] a, input logic [7:0] base);
    hit3 = {a == base + 8'h08, a == base + 8'h04, a == base};
  endfunction : hit3

  // slot index of a one-hot timer hit
  function automatic logic [1:0] slot(input logic [2:0] h);
    slot = h[2] ? 2'h2 : (h[1] ? 2'h1 : 2'h0);
  endfunction : slot

  // three shared timers; postscale bits 6:3 are deliberately not wired
  // all three run side by side, so a selection switch finds a live base
  for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
    spw_timer u_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (tctl_ff[i][TCTL_RUN_BIT]),
      .frz     (sleep_req),
      .pre_sel (spw_pre_t'(tctl_ff[i][1:0])),
      .limit   (plim_ff[i]),
      .cnt     (cnt_w[i]),
      .low     (low_w[i]),
      .wrap    (wrap_w[i])
    );
  end

  // apb phases: read data is captured in setup so it comes from a flop
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite;
  assign pready = psel & penable;
  assign prdata  = prdata_ff;
  assign pslverr = slverr_ff & pready;

  // selected time base; code 3 selects no timer and stops the channel
  // (the base then reads zero, so only a zero duty can still clear the output)
  assign pwm_mode = (ctrl_ff[3:2] == CTRL_MODE_PWM);
  assign s_wrap   = (tsel_ff != 2'h3) & wrap_w[tsel_ff];
  assign s_base   = (tsel_ff != 2'h3) ? {cnt_w[tsel_ff], low_w[tsel_ff]} : 10'h000;
  assign duty_new = {duty_high_ff, ctrl_ff[CTRL_DLO_LSB+1:CTRL_DLO_LSB]};
  assign duty_buf = {shadow_ff, latch_ff};

  // read mux
  // unmapped words read zero and raise pslverr in the access phase
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (paddr == ADR_CTRL) begin
      rd_val = {24'h000000, ctrl_ff};
    end else if (paddr == ADR_DUTYH) begin
      rd_val = {24'h000000, duty_high_ff};
    end else if (paddr == ADR_SHADOW) begin
      rd_val = {24'h000000, shadow_ff};
    end else if (paddr == ADR_TSEL) begin
      rd_val = {30'h00000000, tsel_ff};
    end else if (paddr == ADR_DIR) begin
      rd_val = {31'h00000000, dir_ff};
    end else if (paddr == ADR_FLAG) begin
      rd_val = {29'h00000000, flag_ff};
    end else if (|hit3(paddr, ADR_TCTL)) begin
      rd_val = {25'h0000000, tctl_ff[slot(hit3(paddr, ADR_TCTL))]};
    end else if (|hit3(paddr, ADR_PLIM)) begin
      rd_val = {24'h000000, plim_ff[slot(hit3(paddr, ADR_PLIM))]};
    end else if (|hit3(paddr, ADR_PCNT)) begin
      rd_val = {24'h000000, cnt_w[slot(hit3(paddr, ADR_PCNT))]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read data and error captured at the setup edge
  // capturing early costs nothing here: pready never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
      slverr_ff <= ~rd_ok;
    end
  end

  // channel configuration registers
  // writes land only in the access cycle, so a lone setup changes nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff      <= RST_CTRL;
      duty_high_ff <= RST_DUTY;
      tsel_ff      <= RST_TSEL;
      dir_ff       <= RST_DIR;
    end else if (wr) begin
      if (paddr == ADR_CTRL) ctrl_ff <= pwdata[7:0];
      if (paddr == ADR_DUTYH) duty_high_ff <= pwdata[7:0];
      if (paddr == ADR_TSEL) tsel_ff <= pwdata[1:0];
      if (paddr == ADR_DIR) dir_ff <= pwdata[0];
    end
  end

  // timer control and period limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_TMR; i++) begin
        tctl_ff[i] <= RST_TCTL;
        plim_ff[i] <= RST_PLIM;
      end
    end else if (wr) begin
      if (|hit3(paddr, ADR_TCTL)) tctl_ff[slot(hit3(paddr, ADR_TCTL))] <= pwdata[6:0];
      if (|hit3(paddr, ADR_PLIM)) plim_ff[slot(hit3(paddr, ADR_PLIM))] <= pwdata[7:0];
    end
  end

  // period flags: a rollover in the clearing cycle still sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 3'h0;
    end else begin
      flag_ff <= (flag_ff & ~((wr && paddr == ADR_FLAG) ? pwdata[2:0] : 3'h0)) | wrap_w;
    end
  end

  // duty buffer: in pwm mode loaded only at the period boundary, frozen in sleep
  // a mid-period write reaches only duty_high_ff and ctrl_ff; the compare uses this buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_ff <= RST_DUTY;
      latch_ff  <= 2'h0;
    end else if (pwm_mode && s_wrap && !sleep_req) begin
      shadow_ff <= duty_high_ff;
      latch_ff  <= ctrl_ff[CTRL_DLO_LSB+1:CTRL_DLO_LSB];
    end else if (!pwm_mode && wr && paddr == ADR_SHADOW) begin
      shadow_ff <= pwdata[7:0];
    end
  end

  // output level: set at the boundary, cleared on match; a duty beyond
  // the period simply never matches, so the level is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff <= 1'b0;
    end else if (!pwm_mode) begin
      out_ff <= 1'b0;
    end else if (sleep_req) begin
      out_ff <= out_ff;
    end else if (s_wrap) begin
      out_ff <= (duty_new != 10'h000);
    end else if (s_base == duty_buf) begin
      out_ff <= 1'b0;
    end
  end

  // pin driver: only in pwm mode and with the direction set to output
  // registered so the pin enable never glitches on a decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= pwm_mode & ~dir_ff;
    end
  end

  assign pwm_output    = out_ff;
  assign pwm_output_oe = oe_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_set_on_wrap : assert property (
    pwm_mode && s_wrap && !sleep_req && duty_new != 10'h000 |=> out_ff)
    else $error("output not set at period start");
  a_zero_duty : assert property (
    pwm_mode && s_wrap && !sleep_req && duty_new == 10'h000 |=> !out_ff)
    else $error("output set with zero duty");
  a_shadow_load : assert property (
    pwm_mode && s_wrap && !sleep_req |=> {shadow_ff, latch_ff} == $past(duty_new))
    else $error("duty not buffered at boundary");
  a_match_clear : assert property (
    pwm_mode && !sleep_req && !s_wrap && s_base == duty_buf |=> !out_ff)
    else $error("output not cleared on match");
  a_shadow_hold : assert property (
    pwm_mode && !s_wrap |=> $stable(shadow_ff) && $stable(latch_ff))
    else $error("duty buffer changed mid-period");
  a_sleep_freeze : assert property (
    pwm_mode && sleep_req && !wr |=> $stable(out_ff) && $stable(shadow_ff))
    else $error("channel moved in sleep");
  a_pin_release : assert property (
    wr && paddr == ADR_CTRL && pwdata[7:0] == 8'h00 |=> ##1 !pwm_output_oe)
    else $error("pin not released after control cleared");
  a_dir_gate : assert property (
    dir_ff |=> !pwm_output_oe)
    else $error("pin driven while direction is input");
  a_flag_set : assert property (
    wrap_w[0] |=> flag_ff[0])
    else $error("period flag missed a rollover");
  a_apb_ready : assert property (
    setup |=> pready)
    else $error("no ready in access phase");

  // level, pin, flag, shadow and bus error guards
  a_idle_low : assert property (
    !pwm_mode |=> !out_ff)
    else $error("output high outside pwm mode");
  a_mode_oe : assert property (
    !pwm_mode |=> !pwm_output_oe)
    else $error("pin driven outside pwm mode");
  a_oe_follow : assert property (
    pwm_mode && !dir_ff |=> pwm_output_oe)
    else $error("pin not driven in pwm mode");
  a_level_hold : assert property (
    pwm_mode && !sleep_req && !s_wrap && s_base != duty_buf |=> out_ff == $past(out_ff))
    else $error("output moved without wrap or match");
  a_shadow_ro : assert property (
    pwm_mode && wr && paddr == ADR_SHADOW && !s_wrap |=> $stable(shadow_ff))
    else $error("shadow took a write in pwm mode");
  a_flag_clear : assert property (
    wr && paddr == ADR_FLAG && pwdata[0] && !wrap_w[0] |=> !flag_ff[0])
    else $error("period flag not cleared");
  a_flag_set_t2 : assert property (
    wrap_w[2] |=> flag_ff[2])
    else $error("period flag missed a rollover");
  a_sleep_flags : assert property (
    sleep_req && !wr |=> $stable(flag_ff))
    else $error("flags moved in sleep");
  a_miss_err : assert property (
    setup && !rd_ok |=> slverr_ff)
    else $error("unmapped address not flagged");

  // main scenarios worth seeing at least once
  c_pulse : cover property (pwm_mode && s_wrap && duty_new != 10'h000 ##[1:1000] !out_ff);
  c_sleep : cover property (pwm_mode && out_ff && sleep_req [*3]);
  c_flag_clear : cover property (wr && paddr == ADR_FLAG && wrap_w != 3'h0);
  c_match_clear : cover property (pwm_mode && !s_wrap && s_base == duty_buf && out_ff);
  c_zero_duty : cover property (pwm_mode && s_wrap && duty_new == 10'h000);
endmodule : spw_pwm

// File: standard_pwm_channel_test.sv
// standard_pwm_channel_test: self-checking bench for the pwm channel top.
// assumes spw_pkg and spw_pwm are compiled first; bench drives apb and sleep.
`timescale 1ns/1ps
module standard_pwm_channel_test;
  import spw_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, sleep_req;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pwm_output, pwm_output_oe, err;
  int          n_fail, num_checks, cyc, hi, per;

  spw_pwm dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .pwm_output(pwm_output), .pwm_output_oe(pwm_output_oe)
  );

  // 10 mhz clock
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  // hang guard, far above the thousand or so cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      $display("ERROR %0t timeout", $time);
      n_fail++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // sample just after the edge so the design's updates have landed
  task automatic tick;
    @(posedge pclk);
    #1;
  endtask : tick

  task automatic sync_rise;
    int n;
    n = 0;
    while (pwm_output !== 1'h0 && n < 3000) begin
      tick();
      n++;
    end
    while (pwm_output !== 1'h1 && n < 3000) begin
      tick();
      n++;
    end
  endtask : sync_rise

  // called just after a rise; returns just after the next rise
  task automatic measure;
    hi = 0;
    do begin
      tick();
      hi++;
    end while (pwm_output === 1'h1 && hi < 3000);
    per = hi;
    while (pwm_output !== 1'h1 && per < 3000) begin
      tick();
      per++;
    end
  endtask : measure

  // timers stopped first so a stale timer cannot drive the channel
  task automatic cfg(input int t, input logic [7:0] lim, input logic [1:0] pre, input logic [9:0] duty);
    for (int j = 0; j < NUM_TMR; j++)
      wr(ADR_TCTL + 8'(4 * j), 32'h0);
    wr(ADR_TSEL, 32'(t));
    wr(ADR_PLIM + 8'(4 * t), {24'h0, lim});
    wr(ADR_CTRL, {26'h0, duty[1:0], CTRL_MODE_PWM, 2'h0});
    wr(ADR_DUTYH, {24'h0, duty[9:2]});
    wr(ADR_TCTL + 8'(4 * t), {25'h0, 4'hf, 1'h1, pre});
  endtask : cfg

  task automatic t_reset;
    logic [7:0]  a [10] = '{ADR_CTRL, ADR_DUTYH, ADR_SHADOW, ADR_TSEL, ADR_DIR,
                            ADR_FLAG, ADR_TCTL, ADR_PLIM, ADR_PCNT, 8'hfc};
    logic [31:0] e [10] = '{32'(RST_CTRL), 32'(RST_DUTY), 32'(RST_DUTY), 32'(RST_TSEL),
                            32'(RST_DIR), 32'h0, 32'(RST_TCTL), 32'(RST_PLIM), 32'h0, 32'h0};
    for (int i = 0; i < 10; i++)
      rdchk(a[i], e[i]);
    chk(32'(err), 32'h1);
    chk(32'(pwm_output_oe), 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_select;
    for (int t = 0; t < NUM_TMR; t++) begin
      cfg(t, 8'(t), 2'h0, 10'h2);
      sync_rise();
      measure();
      chk(32'(hi), 32'h2);
      chk(32'(per), 32'(4 * (t + 1)));
    end
    $display("test select done");
  endtask : t_select

  task automatic t_prescale;
    int f [3] = '{1, 4, 16};
    for (int i = 0; i < 3; i++) begin
      cfg(0, 8'h1, 2'(i), 10'h6);
      sync_rise();
      measure();
      chk(32'(hi), 32'(6 * f[i]));
      chk(32'(per), 32'(8 * f[i]));
    end
    rdchk(ADR_SHADOW, 32'h1);
    wr(ADR_SHADOW, 32'h55);
    rdchk(ADR_SHADOW, 32'h1);
    apb(1'h0, ADR_FLAG, 32'h0);
    chk(rd & 32'h1, 32'h1);
    wr(ADR_TCTL, 32'h0);
    wr(ADR_FLAG, 32'h7);
    rdchk(ADR_FLAG, 32'h0);
    $display("test prescale done");
  endtask : t_prescale

  // duty rewritten early in a pulse: that pulse keeps its width
  task automatic t_update;
    cfg(0, 8'h1, 2'h1, 10'h6);
    sync_rise();
    fork
      measure();
      begin
        wr(ADR_CTRL, {26'h0, 2'h2, CTRL_MODE_PWM, 2'h0});
        wr(ADR_DUTYH, 32'h0);
      end
    join
    chk(32'(hi), 32'd24);
    measure();
    chk(32'(hi), 32'h8);
    $display("test update done");
  endtask : t_update

  task automatic t_levels;
    logic all1, any1;
    cfg(0, 8'h0, 2'h0, 10'h8);
    repeat (20) tick();
    all1 = 1'h1;
    for (int i = 0; i < 16; i++) begin
      tick();
      all1 = all1 & pwm_output;
    end
    chk(32'(all1), 32'h1);
    cfg(0, 8'h0, 2'h0, 10'h0);
    repeat (20) tick();
    any1 = 1'h0;
    for (int i = 0; i < 16; i++) begin
      tick();
      any1 = any1 | pwm_output;
    end
    chk(32'(any1), 32'h0);
    $display("test levels done");
  endtask : t_levels

  task automatic t_sleep;
    logic [31:0] c1;
    logic        o;
    // period of 64 clocks with a 60-clock pulse, so sleep lands while high
    cfg(0, 8'h0f, 2'h0, 10'h03c);
    repeat (80) tick();
    @(posedge pclk);
    sleep_req <= 1'h1;
    apb(1'h0, ADR_PCNT, 32'h0);
    c1 = rd;
    o  = pwm_output;
    repeat (20) tick();
    rdchk(ADR_PCNT, c1);
    chk(32'(pwm_output), 32'(o));
    chk(32'(o), 32'h1);
    @(posedge pclk);
    sleep_req <= 1'h0;
    repeat (10) tick();
    apb(1'h0, ADR_PCNT, 32'h0);
    chk(32'(rd !== c1), 32'h1);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_pin;
    cfg(0, 8'h0, 2'h0, 10'h2);
    repeat (3) tick();
    chk(32'(pwm_output_oe), 32'h1);
    wr(ADR_DIR, 32'h1);
    repeat (2) tick();
    chk(32'(pwm_output_oe), 32'h0);
    wr(ADR_DIR, 32'h0);
    wr(ADR_CTRL, 32'h0);
    repeat (2) tick();
    chk(32'(pwm_output_oe), 32'h0);
    chk(32'(pwm_output), 32'h0);
    $display("test pin done");
  endtask : t_pin

  // main sequence
  initial begin
    {psel, penable, pwrite, sleep_req, presetn} = 5'h0;
    paddr      = 8'h0;
    pwdata     = 32'h0;
    n_fail     = 0;
    num_checks = 0;
    cyc        = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    wr(ADR_DIR, 32'h0);
    t_select();
    t_prescale();
    t_update();
    t_levels();
    t_sleep();
    t_pin();
    close_out();
  end
endmodule : standard_pwm_channel_test
